/* File: rtl/lbi_pkg.sv */
// shared constants and types for the led brightness two-wire link
package lbi_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_HZ_SLOW = 10_000;
  localparam int PWM_HZ_FAST = 23_000;
  localparam int PWM_STEPS = 16;
  localparam int SCL_HZ = 100_000;
  localparam int SCL_QTR_CNT = CLK_HZ / (4 * SCL_HZ);

  // --------------------------------------------------------------
  // addressing and register map
  // --------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h36;
  localparam logic [7:0] REG_BANK_ENABLE = 8'h10;
  localparam logic [7:0] REG_DISPLAY_LEVELS = 8'ha0;
  localparam logic [7:0] REG_KEYPAD_LEVEL = 8'hb0;
  localparam logic [7:0] RST_BANK_ENABLE = 8'h00;
  localparam logic [7:0] RST_DISPLAY_LEVELS = 8'h00;
  localparam logic [7:0] RST_KEYPAD_LEVEL = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int MAIN_BANK_ON_BIT = 0;
  localparam int SUB_BANK_ON_BIT = 1;
  localparam int KEYPAD_SINK_ON_BIT = 2;
  localparam int MAIN_LEVEL_LSB = 0;
  localparam int SUB_LEVEL_LSB = 4;
  localparam int KEYPAD_LEVEL_LSB = 0;

  // keypad analog scale in percent of full scale, by code
  localparam logic [6:0] KEY_PCT_00 = 7'h14;
  localparam logic [6:0] KEY_PCT_01 = 7'h28;
  localparam logic [6:0] KEY_PCT_10 = 7'h46;
  localparam logic [6:0] KEY_PCT_11 = 7'h64;

  // --------------------------------------------------------------
  // state enumerations
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE, DS_RECV, DS_ACK, DS_SEND, DS_SACK
  } lbi_dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_BIT, HS_ACK, HS_RSTART, HS_STOP
  } lbi_host_st_t;
endpackage

/* File: rtl/lbi_if.sv */
// two-wire link joining the brightness device and its bus master
`timescale 1ns/1ps
`default_nettype none
interface lbi_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // open-drain resolution: any enabled driver pulls low
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

/* File: rtl/lbi_dev.sv */
// led brightness device end: two-wire slave, registers, pwm, keypad
`timescale 1ns/1ps
`default_nettype none
// How it works
// - bytes are eight bits, msb first
// - device pulls data low through ninth pulse
// - master clocks ack pulse, releases data line
// - first byte holds address, only 0110110 answered
// - direction bit zero writes, one reads
// - write: register address byte, then data byte
// - enable register at 10h; all clear at reset
// - enable bits: main, sub, keypad sinks
// - two four-bit display level codes at A0h
// - sixteen pwm duty steps, 1/16 to full
// - pwm rate fixed by build option, 10k/23k
// - keypad code in B0h bits 1:0
// - keypad uses analog scale 100/70/40/20 percent
// - start and stop are data edges, clock high
// - repeated start restarts address reception
// - master changes data only while clock low
module lbi_dev
  import lbi_pkg::*;
#(
  parameter int PWM_HZ = PWM_HZ_SLOW
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  lbi_if.dev bus,
  output logic o_main_display_sinks,
  output logic o_sub_display_sinks,
  output logic o_keypad_current_sink,
  output logic [1:0] o_keypad_level_code,
  output logic [6:0] o_keypad_scale_pct
);
  // ----------------------------------------------------------------
  // build-time checks and derived counts
  // ----------------------------------------------------------------
  localparam int PWM_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int DIV_W = $clog2(PWM_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PWM_DIV - 1);

  // only the two documented rates are served
  if (!(PWM_HZ == PWM_HZ_SLOW || PWM_HZ == PWM_HZ_FAST)) begin : g_chk
    $error("lbi_dev: PWM_HZ must be one of the two fixed rates");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lbi_dev_st_t st;
    logic scl_p;
    logic sda_p;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] idx;
    logic rw;
    logic mack;
    logic [7:0] raddr;
    logic [7:0] bank_enable_control;
    logic [7:0] display_bank_levels;
    logic [7:0] keypad_level;
    logic sda_oe;
    logic [DIV_W-1:0] div;
    logic [3:0] phase;
    logic main_on;
    logic sub_on;
    logic key_on;
    logic [6:0] key_pct;
  } lbi_dev_s_t;

  lbi_dev_s_t q;
  lbi_dev_s_t d;

  // register read mux; unmapped addresses read as zero
  function automatic logic [7:0] reg_read(input lbi_dev_s_t s);
    logic [7:0] v;
    v = UNMAPPED_READ;
    if (s.raddr == REG_BANK_ENABLE) begin
      v = s.bank_enable_control;
    end else if (s.raddr == REG_DISPLAY_LEVELS) begin
      v = s.display_bank_levels;
    end else if (s.raddr == REG_KEYPAD_LEVEL) begin
      v = s.keypad_level;
    end
    return v;
  endfunction

  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rd_byte;
  logic [3:0] main_level_code;
  logic [3:0] sub_level_code;
  logic [1:0] keypad_level_code;

  // ----------------------------------------------------------------
  // line events; inputs are already synchronous to i_clk_sys
  // ----------------------------------------------------------------
  assign start_seen = q.scl_p & bus.scl & q.sda_p & ~bus.sda;
  assign stop_seen = q.scl_p & bus.scl & ~q.sda_p & bus.sda;
  assign scl_rise = ~q.scl_p & bus.scl;
  assign scl_fall = q.scl_p & ~bus.scl;
  assign rd_byte = reg_read(q);
  assign main_level_code = q.display_bank_levels[MAIN_LEVEL_LSB +: 4];
  assign sub_level_code = q.display_bank_levels[SUB_LEVEL_LSB +: 4];
  assign keypad_level_code = q.keypad_level[KEYPAD_LEVEL_LSB +: 2];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.scl_p = bus.scl;
    d.sda_p = bus.sda;

    // protocol engine; start and stop override any byte in flight
    if (start_seen) begin
      d.st = DS_RECV;
      d.bitcnt = 4'h0;
      d.idx = 2'h0;
      d.rw = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      d.st = DS_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        DS_RECV: begin
          // sample on the rising edge: data is stable while clock high
          if (scl_rise && q.bitcnt != 4'h8) begin
            d.shreg = {q.shreg[6:0], bus.sda};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall && q.bitcnt == 4'h8) begin
            d.st = DS_ACK;
            d.sda_oe = 1'b1;
            if (q.idx == 2'h0) begin
              if (q.shreg[7:1] == SLAVE_ADDR) begin
                d.rw = q.shreg[0];
              end else begin
                d.st = DS_IDLE; // foreign address: stay off the line
                d.sda_oe = 1'b0;
              end
            end else if (q.idx == 2'h1) begin
              d.raddr = q.shreg;
            end else begin
              // every further byte lands in the selected register
              if (q.raddr == REG_BANK_ENABLE) begin
                d.bank_enable_control = q.shreg;
              end else if (q.raddr == REG_DISPLAY_LEVELS) begin
                d.display_bank_levels = q.shreg;
              end else if (q.raddr == REG_KEYPAD_LEVEL) begin
                d.keypad_level = q.shreg;
              end
            end
          end
        end
        DS_ACK: begin
          // hold low across the whole ninth pulse, release on its fall
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bitcnt = 4'h0;
            if (q.rw) begin
              d.st = DS_SEND;
              d.shreg = rd_byte;
              d.sda_oe = ~rd_byte[7];
            end else begin
              d.st = DS_RECV;
              d.idx = (q.idx == 2'h2) ? 2'h2 : q.idx + 2'h1;
            end
          end
        end
        DS_SEND: begin
          // shift on the falling edge so data settles while clock low
          if (scl_fall) begin
            if (q.bitcnt == 4'h7) begin
              d.st = DS_SACK;
              d.sda_oe = 1'b0;
            end else begin
              d.shreg = {q.shreg[6:0], 1'b0};
              d.sda_oe = ~q.shreg[6];
              d.bitcnt = q.bitcnt + 4'h1;
            end
          end
        end
        DS_SACK: begin
          if (scl_rise) begin
            d.mack = ~bus.sda;
          end
          // a master nack ends the read; wait for stop or start
          if (scl_fall) begin
            d.bitcnt = 4'h0;
            if (q.mack) begin
              d.st = DS_SEND;
              d.shreg = rd_byte;
              d.sda_oe = ~rd_byte[7];
            end else begin
              d.st = DS_IDLE;
            end
          end
        end
        default: begin
          d.st = DS_IDLE;
        end
      endcase
    end

    // fixed-rate pwm: sixteen phases per period
    if (q.div == DIV_LAST) begin
      d.div = '0;
      d.phase = q.phase + 4'h1;
    end else begin
      d.div = q.div + DIV_W'(1);
    end
    // code n lights n+1 of sixteen phases, so 0 still gives 1/16
    d.main_on = q.bank_enable_control[MAIN_BANK_ON_BIT] &
                (q.phase <= main_level_code);
    d.sub_on = q.bank_enable_control[SUB_BANK_ON_BIT] &
               (q.phase <= sub_level_code);
    d.key_on = q.bank_enable_control[KEYPAD_SINK_ON_BIT];

    // keypad level is a steady analog scale, never chopped
    case (keypad_level_code)
      2'b00: d.key_pct = KEY_PCT_00;
      2'b01: d.key_pct = KEY_PCT_01;
      2'b10: d.key_pct = KEY_PCT_10;
      default: d.key_pct = KEY_PCT_11;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.st <= DS_IDLE;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.bank_enable_control <= RST_BANK_ENABLE;
      q.display_bank_levels <= RST_DISPLAY_LEVELS;
      q.keypad_level <= RST_KEYPAD_LEVEL;
      q.key_pct <= KEY_PCT_00;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: the driven value is always low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = q.sda_oe;
  assign o_main_display_sinks = q.main_on;
  assign o_sub_display_sinks = q.sub_on;
  assign o_keypad_current_sink = q.key_on;
  assign o_keypad_level_code = keypad_level_code;
  assign o_keypad_scale_pct = q.key_pct;
endmodule
`default_nettype wire

/* File: rtl/lbi_host.sv */
// two-wire bus master end: one register write or read per request
`timescale 1ns/1ps
`default_nettype none
module lbi_host
  import lbi_pkg::*;
#(
  parameter int QTR_CNT = SCL_QTR_CNT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  lbi_if.host bus,
  input wire logic i_start,
  input wire logic i_read,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_ack_err
);
  // ----------------------------------------------------------------
  // checks and state
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(QTR_CNT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(QTR_CNT - 1);

  // the slave needs a few clocks per quarter to see each edge
  if (QTR_CNT < 4) begin : g_chk
    $error("lbi_host: QTR_CNT must be at least 4");
  end

  typedef struct packed {
    lbi_host_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] qtr;
    logic [2:0] bitcnt;
    logic [2:0] idx;
    logic rd;
    logic [7:0] shreg;
    logic [7:0] raddr;
    logic [7:0] wdata;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic done;
    logic ack_err;
    logic [7:0] rdata;
  } lbi_host_s_t;

  lbi_host_s_t q;
  lbi_host_s_t d;
  logic tick;

  // byte sent in each slot; slot 4 is the read byte, line released
  function automatic logic [7:0] tx_byte(input logic [2:0] i,
                                         input lbi_host_s_t s);
    logic [7:0] v;
    v = 8'hff;
    case (i)
      3'h0: v = {SLAVE_ADDR, 1'b0};
      3'h1: v = s.raddr;
      3'h2: v = s.wdata;
      3'h3: v = {SLAVE_ADDR, 1'b1};
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  assign tick = (q.cnt == CNT_LAST);

  // ----------------------------------------------------------------
  // sequencer: four quarter-steps per bit, clock low in q0 and q1
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.cnt = tick ? '0 : q.cnt + CNT_W'(1);
    if (q.st == HS_IDLE) begin
      d.cnt = '0;
      d.qtr = 2'h0;
      if (i_start) begin
        d.st = HS_START;
        d.busy = 1'b1;
        d.rd = i_read;
        d.raddr = i_reg_addr;
        d.wdata = i_wdata;
        d.ack_err = 1'b0;
        d.idx = 3'h0;
      end
    end else if (tick) begin
      d.qtr = q.qtr + 2'h1;
      case (q.st)
        HS_START, HS_RSTART: begin
          // data falls while clock is high
          case (q.qtr)
            2'h0: d.sda_oe = (q.st == HS_START);
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.st = HS_BIT;
              d.bitcnt = 3'h0;
              d.idx = (q.st == HS_START) ? 3'h0 : 3'h3;
              d.shreg = tx_byte(d.idx, q);
            end
          endcase
        end
        HS_BIT: begin
          case (q.qtr)
            2'h0: d.sda_oe = ~q.shreg[7];
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.shreg = {q.shreg[6:0], bus.sda};
            default: begin
              d.scl_oe = 1'b1;
              d.bitcnt = q.bitcnt + 3'h1;
              if (q.bitcnt == 3'h7) begin
                d.st = HS_ACK;
              end
            end
          endcase
        end
        HS_ACK: begin
          // release for the slave's ack; a final read byte gets a nack
          case (q.qtr)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.idx == 3'h4) begin
                d.rdata = q.shreg;
              end else begin
                d.ack_err = q.ack_err | bus.sda;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              if (q.ack_err || q.idx == 3'h4 || q.idx == 3'h2) begin
                d.st = HS_STOP;
              end else if (q.idx == 3'h1 && q.rd) begin
                d.st = HS_RSTART;
              end else begin
                d.st = HS_BIT;
                d.bitcnt = 3'h0;
                d.idx = q.idx + 3'h1;
                d.shreg = tx_byte(d.idx, q);
              end
            end
          endcase
        end
        HS_STOP: begin
          // data rises while clock is high
          case (q.qtr)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: begin
              d.st = HS_IDLE;
              d.busy = 1'b0;
              d.done = 1'b1;
            end
          endcase
        end
        default: begin
          d.st = HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.st <= HS_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = q.sda_oe;
  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_rdata = q.rdata;
  assign o_ack_err = q.ack_err;
endmodule
`default_nettype wire

/* File: testbench/lbi_link_checker.sv */
// concurrent checks on the two-wire link between host and device
`timescale 1ns/1ps
`default_nettype none
module lbi_link_checker
  import lbi_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------
  // frame position rebuilt from the wire
  // --------------------------------------------------------------
  logic scl_q, sda_q, rd_q, rise_w, start_w;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  assign rise_w = scl && !scl_q;
  assign start_w = scl && scl_q && sda_q && !sda;

  // a start of any kind restarts the count, so repeated starts line up
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q <= 1'b0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_w) begin
        bit_q <= 4'h0;
        byte_q <= 2'h0;
      end else if (rise_w && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        byte_q <= (byte_q == 2'h3) ? byte_q : byte_q + 2'h1;
      end else if (rise_w) begin
        bit_q <= bit_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
        rd_q <= (byte_q == 2'h0 && bit_q == 4'h7) ? sda : rd_q;
      end
    end
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  sequence first_low;
    ##[1:40] ($fell(scl) && !sda);
  endsequence
  sequence bus_idle;
    (scl && sda && !m_scl_oe) [*3];
  endsequence

  ack_onset_a: assert property (
    $fell(scl) && bit_q == 4'h8 && !(rd_q && byte_q != 2'h0)
    |-> ##[1:3] s_sda_oe) else $error("no ack after eighth bit");
  ack_low_a: assert property (
    rise_w && bit_q == 4'h8 && !(rd_q && byte_q != 2'h0) |-> !sda)
    else $error("data line high in ack pulse");
  ack_release_a: assert property (
    $fell(scl) && bit_q == 4'h0 && s_sda_oe && !rd_q
    |-> ##[1:3] !s_sda_oe) else $error("ack held past ninth pulse");
  host_release_a: assert property (
    rise_w && bit_q == 4'h8 |-> !m_sda_oe)
    else $error("host drives data in ack pulse");
  dev_stable_a: assert property (
    scl && scl_q |-> $stable(s_sda_oe))
    else $error("device moved data while clock high");
  data_stable_a: assert property (
    scl && scl_q && bit_q >= 4'h2 |-> $stable(sda))
    else $error("data changed while clock high");
  addr_msb_a: assert property (
    rise_w && bit_q == 4'h8 && byte_q == 2'h0 |-> sh_q[7:1] == SLAVE_ADDR)
    else $error("wrong address on wire");
  start_form_a: assert property (
    start_w |-> first_low) else $error("start not followed by clock");
  stop_idle_a: assert property (
    scl && scl_q && !sda_q && sda |-> bus_idle)
    else $error("stop not followed by idle bus");
endmodule
`default_nettype wire

/* File: testbench/tb_led_brightness_i2c_slave.sv */
// self-checking bench: host end and device end on one link
`timescale 1ns/1ps
`default_nettype none
module tb_led_brightness_i2c_slave
  import lbi_pkg::*;
;
  localparam int PDIV = CLK_HZ / (PWM_HZ_SLOW * PWM_STEPS);
  logic i_clk_sys, i_rst, i_start, i_read;
  logic [7:0] i_reg_addr, i_wdata, o_rdata;
  logic o_busy, o_done, o_ack_err;
  logic o_main_display_sinks, o_sub_display_sinks, o_keypad_current_sink;
  logic [1:0] o_keypad_level_code;
  logic [6:0] o_keypad_scale_pct;
  logic [2:0] sinks;
  logic [8:0] mon_e;
  logic [8:0] exp_q[$];
  logic [31:0] seed;
  logic [7:0] regs [0:3] = '{8'h10, 8'ha0, 8'hb0, 8'h20};
  logic [6:0] pct [0:3] = '{7'h14, 7'h28, 7'h46, 7'h64};
  int bad_count = 0;
  int check_count = 0;
  assign sinks = {o_keypad_current_sink, o_sub_display_sinks,
                  o_main_display_sinks};

  lbi_if link();
  lbi_dev #(.PWM_HZ(PWM_HZ_SLOW)) i_lbi_dev (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(link),
    .o_main_display_sinks(o_main_display_sinks),
    .o_sub_display_sinks(o_sub_display_sinks),
    .o_keypad_current_sink(o_keypad_current_sink),
    .o_keypad_level_code(o_keypad_level_code),
    .o_keypad_scale_pct(o_keypad_scale_pct));
  // short quarter bit keeps each transfer near 500 clocks
  lbi_host #(.QTR_CNT(4)) i_lbi_host (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(link), .i_start(i_start),
    .i_read(i_read), .i_reg_addr(i_reg_addr), .i_wdata(i_wdata),
    .o_busy(o_busy), .o_done(o_done), .o_rdata(o_rdata),
    .o_ack_err(o_ack_err));
  lbi_link_checker i_lbi_link_checker (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .m_scl_oe(link.m_scl_oe),
    .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe),
    .scl(link.scl), .sda(link.sda));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, got, want);
    end
  endtask

  // one request; the expected answer goes to the monitor's queue
  task automatic xfer(input logic rd, input logic [7:0] ra,
                      input logic [7:0] wd, input logic [7:0] ex);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    i_read = rd;
    i_reg_addr = ra;
    i_wdata = wd;
    i_start = 1'b1;
    exp_q.push_back({rd, ex});
    @(negedge i_clk_sys);
    i_start = 1'b0;
    chk(16'(o_busy), 16'h0001);
    while (o_done !== 1'b1 && n < 3000) begin
      @(negedge i_clk_sys);
      n++;
    end
    // a hung transfer ends the run as a failure
    if (n >= 3000) begin
      bad_count++;
      $display("Error %0t: transfer never finished", $time);
      final_report();
    end
  endtask

  // any 992 straight cycles hold exactly one pwm period
  task automatic duty(input int c);
    int na, nb;
    na = 0;
    nb = 0;
    repeat (PDIV * 16) begin
      @(negedge i_clk_sys);
      if (o_main_display_sinks === 1'b1) na++;
      if (o_sub_display_sinks === 1'b1) nb++;
    end
    chk(16'(na), 16'((c + 1) * PDIV));
    chk(16'(nb), 16'((16 - c) * PDIV));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // processes
  // --------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // done is a one-cycle pulse, so the falling edge sees it once
  always @(negedge i_clk_sys) begin
    if (o_done === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      check_count++;
      if (o_ack_err !== 1'b0 || o_busy !== 1'b0 ||
          (mon_e[8] && o_rdata !== mon_e[7:0])) begin
        bad_count++;
        $display("Error %0t: rdata %h want %h", $time, o_rdata, mon_e[7:0]);
      end
    end
  end

  // watchdog sized well past the longest expected run
  initial begin
    repeat (80000) @(posedge i_clk_sys);
    bad_count++;
    final_report();
  end

  initial begin
    seed = 32'h1fbbd9c6;
    i_rst = 1'b1;
    i_start = 1'b0;
    i_read = 1'b0;
    i_reg_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (5) @(negedge i_clk_sys);
    i_rst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, regs[k], 8'h00, 8'h00);
    end
    chk(16'(sinks), 16'h0000);
    $display("reset values done");
    // random write then readback, unmapped place reads zero
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      xfer(1'b0, regs[k], seed[7:0], 8'h00);
      xfer(1'b1, regs[k], seed[15:8],
           k < 3 ? seed[7:0] : UNMAPPED_READ);
    end
    $display("readback done");
    xfer(1'b0, REG_DISPLAY_LEVELS, 8'hff, 8'h00);
    for (int e = 0; e < 8; e++) begin
      seed = xs(seed);
      xfer(1'b0, REG_BANK_ENABLE, {seed[4:0], 3'(e)}, 8'h00);
      chk(16'(sinks), 16'(e));
    end
    $display("enables done");
    xfer(1'b0, REG_BANK_ENABLE, 8'h03, 8'h00);
    for (int c = 0; c < 16; c++) begin
      xfer(1'b0, REG_DISPLAY_LEVELS, {4'(15 - c), 4'(c)},
           8'h00);
      duty(c);
    end
    $display("pwm done");
    for (int c = 0; c < 4; c++) begin
      seed = xs(seed);
      xfer(1'b0, REG_KEYPAD_LEVEL, {seed[5:0], 2'(c)}, 8'h00);
      xfer(1'b1, REG_KEYPAD_LEVEL, 8'h00, {seed[5:0], 2'(c)});
      chk(16'(o_keypad_level_code), 16'(c));
      chk(16'(o_keypad_scale_pct), 16'(pct[c]));
    end
    $display("keypad done");
    // second reset in mid-run must clear the levels again; one clock
    // first, so the monitor takes the last done pulse before it
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    xfer(1'b1, REG_DISPLAY_LEVELS, 8'h00, 8'h00);
    chk(16'(sinks), 16'h0000);
    $display("second reset done");
    final_report();
  end
endmodule
`default_nettype wire
